// ===== ipr_resolver.sv
/*
 * Interrupt priority resolver: two priority select registers, group level
 * decode, polled arbitration, per-level nesting and vector call timing.
 * Assumes request flags and enables come from peripheral logic as levels,
 * and that the core pulses ret_from_irq when a service routine returns.
 */
// Design decision made here: the plain strobed port.
// What this block does
// - Six groups, one bit per select register
// - High and low bits give level 0..3
// - Bit 0: external 0, PWM
// - Bit 1: timer 0, watchdog, SPI
// - Bit 2: external 1, comparator, ADC
// - Bit 3: timer 1, keyboard interface
// - Bit 4: serial, low voltage detect
// - Bit 5: timer 2, IIC
// - Same-level simultaneous requests use fixed polling
// - Poll order ext0 first through IIC last
// - Equal or higher service blocks new request
// - Response takes at least seven machine cycles
// - Global enable gates all, then individual enables
`timescale 1ns/10ps
module ipr_resolver
	import ipr_pkg::*;
#(
	parameter int MACHINE_CYCLE_CLKS = 1
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [IPR_NUM_SRC-1:0] src_request,
	input wire logic [IPR_NUM_SRC-1:0] src_enable,
	input wire logic global_irq_enable,
	input wire logic ret_from_irq,
	output logic irq_take,
	output logic [15:0] irq_vector,
	output logic [IPR_SRC_W-1:0] irq_source,
	output logic [IPR_NUM_SRC-1:0] irq_ack,
	output logic service_busy,
	output logic [IPR_LVL_W-1:0] service_level
);

	localparam int DETECT_CLKS = IPR_DETECT_MCYC * MACHINE_CYCLE_CLKS;
	localparam int CALL_CLKS = IPR_CALL_MCYC * MACHINE_CYCLE_CLKS;
	localparam int CNT_W = $clog2(CALL_CLKS + DETECT_CLKS + 1) + 1;
	localparam logic [CNT_W-1:0] DETECT_LAST = CNT_W'(DETECT_CLKS - 1);
	localparam logic [CNT_W-1:0] CALL_LAST = CNT_W'(CALL_CLKS - 1);

	logic [7:0] prio_low_q;
	logic [7:0] prio_high_q;
	logic [7:0] reg_rdata_q;
	logic [7:0] reg_rdata_d;

	logic [IPR_NUM_GRP*IPR_LVL_W-1:0] grp_level;
	logic [IPR_NUM_SRC*IPR_LVL_W-1:0] src_level;

	logic [IPR_NUM_LVL-1:0] active_q;
	logic [IPR_NUM_LVL-1:0] active_d;
	logic cur_valid;
	logic [IPR_LVL_W-1:0] cur_level;

	logic [IPR_NUM_SRC-1:0] eligible;
	logic win_found;
	logic [IPR_SRC_W-1:0] win_idx;
	logic [IPR_LVL_W-1:0] win_level;

	ipr_state_e state_q;
	ipr_state_e state_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [IPR_SRC_W-1:0] pend_idx_q;
	logic [IPR_LVL_W-1:0] pend_level_q;
	logic take_now;

	logic irq_take_q;
	logic [15:0] irq_vector_q;
	logic [IPR_SRC_W-1:0] irq_source_q;
	logic [IPR_NUM_SRC-1:0] irq_ack_q;

	// Priority select registers; only six group bits are stored
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prio_low_q <= IPR_PRIO_RESET;
			prio_high_q <= IPR_PRIO_RESET;
		end else if (reg_wr) begin
			if (reg_addr == IPR_OFF_PRIO_LOW) begin
				prio_low_q <= reg_wdata & IPR_PRIO_MASK;
			end
			if (reg_addr == IPR_OFF_PRIO_HIGH) begin
				prio_high_q <= reg_wdata & IPR_PRIO_MASK;
			end
		end
	end

	// Read mux; unmapped addresses answer zero
	always_comb begin
		reg_rdata_d = IPR_READ_NONE;
		case (reg_addr)
			IPR_OFF_PRIO_LOW: begin
				reg_rdata_d = prio_low_q & IPR_PRIO_MASK;
			end
			IPR_OFF_PRIO_HIGH: begin
				reg_rdata_d = prio_high_q & IPR_PRIO_MASK;
			end
			IPR_OFF_SERVICE_STAT: begin
				reg_rdata_d = {cur_valid, 3'h0, active_q};
			end
			IPR_OFF_PENDING_LO: begin
				reg_rdata_d = eligible[7:0];
			end
			IPR_OFF_PENDING_HI: begin
				reg_rdata_d = {2'h0, eligible[IPR_NUM_SRC-1:8]};
			end
			default: begin
				reg_rdata_d = IPR_READ_NONE;
			end
		endcase
	end

	// Data stands only in the cycle after the read strobe
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata_q <= IPR_READ_NONE;
		end else if (reg_rd) begin
			reg_rdata_q <= reg_rdata_d;
		end else begin
			reg_rdata_q <= IPR_READ_NONE;
		end
	end

	assign reg_rdata = reg_rdata_q;

	// One level decoder per group
	for (genvar g = 0; g < IPR_NUM_GRP; g++) begin : g_grp
		ipr_group_level u_lvl (
			.sel_low(prio_low_q[g]),
			.sel_high(prio_high_q[g]),
			.level(grp_level[g*IPR_LVL_W +: IPR_LVL_W])
		);
	end

	// Each source inherits its group's level via the group map
	for (genvar s = 0; s < IPR_NUM_SRC; s++) begin : g_src
		assign src_level[s*IPR_LVL_W +: IPR_LVL_W] =
			grp_level[32'(IPR_SRC_GROUP[s])*IPR_LVL_W +: IPR_LVL_W];
	end

	// Highest level now in service
	always_comb begin
		cur_valid = 1'b0;
		cur_level = '0;
		for (int l = 0; l < IPR_NUM_LVL; l++) begin
			if (active_q[l]) begin
				cur_valid = 1'b1;
				cur_level = IPR_LVL_W'(l);
			end
		end
	end

	// Eligibility: global gate, own enable, and strictly above service level
	always_comb begin
		for (int s = 0; s < IPR_NUM_SRC; s++) begin
			eligible[s] = global_irq_enable && src_enable[s] && src_request[s] &&
				(!cur_valid ||
				src_level[s*IPR_LVL_W +: IPR_LVL_W] > cur_level);
		end
	end

	ipr_poll_pick #(
		.N(IPR_NUM_SRC)
	) u_pick (
		.eligible(eligible),
		.src_level(src_level),
		.found(win_found),
		.win_idx(win_idx),
		.win_level(win_level)
	);

	// Detect, then long call, then vector; never shorter than seven cycles
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		take_now = 1'b0;
		case (state_q)
			IPR_ST_IDLE: begin
				cnt_d = '0;
				if (win_found) begin
					state_d = IPR_ST_DETECT;
				end
			end
			IPR_ST_DETECT: begin
				if (cnt_q == DETECT_LAST) begin
					cnt_d = '0;
					state_d = IPR_ST_CALL;
				end else begin
					cnt_d = cnt_q + CNT_W'(1);
				end
			end
			IPR_ST_CALL: begin
				if (cnt_q == CALL_LAST) begin
					cnt_d = '0;
					take_now = 1'b1;
					state_d = IPR_ST_IDLE;
				end else begin
					cnt_d = cnt_q + CNT_W'(1);
				end
			end
			default: begin
				cnt_d = '0;
				state_d = IPR_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q <= IPR_ST_IDLE;
			cnt_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// Winner latched at detection; once the call starts it is committed
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pend_idx_q <= '0;
			pend_level_q <= '0;
		end else if (state_q == IPR_ST_IDLE && win_found) begin
			pend_idx_q <= win_idx;
			pend_level_q <= win_level;
		end
	end

	// Nesting stack as one bit per level; return clears the highest
	always_comb begin
		active_d = active_q;
		if (ret_from_irq && cur_valid) begin
			active_d[cur_level] = 1'b0;
		end
		if (take_now) begin
			active_d[pend_level_q] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			active_q <= '0;
		end else begin
			active_q <= active_d;
		end
	end

	// Vector hand-off to the core and acknowledge to the winning source
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_take_q <= 1'b0;
			irq_vector_q <= '0;
			irq_source_q <= '0;
			irq_ack_q <= '0;
		end else begin
			irq_take_q <= take_now;
			irq_ack_q <= '0;
			if (take_now) begin
				irq_vector_q <= IPR_SRC_VECTOR[pend_idx_q];
				irq_source_q <= pend_idx_q;
				irq_ack_q[pend_idx_q] <= 1'b1;
			end
		end
	end

	assign irq_take = irq_take_q;
	assign irq_vector = irq_vector_q;
	assign irq_source = irq_source_q;
	assign irq_ack = irq_ack_q;
	assign service_busy = cur_valid;
	assign service_level = cur_level;

endmodule

// ===== ipr_pkg.sv
/*
 * Constants of the interrupt priority resolver: register offsets and
 * layouts, polling order, group map, vector table and response timing.
 * Assumes an 8-bit register port with byte-wide special function addresses.
 */
package ipr_pkg;

	localparam int IPR_NUM_SRC = 14;
	localparam int IPR_NUM_GRP = 6;
	localparam int IPR_SRC_W = 4;
	localparam int IPR_LVL_W = 2;
	localparam int IPR_NUM_LVL = 4;

	localparam logic [7:0] IPR_OFF_PRIO_LOW = 8'hA9;
	localparam logic [7:0] IPR_OFF_PRIO_HIGH = 8'hB9;
	localparam logic [7:0] IPR_OFF_SERVICE_STAT = 8'hF0;
	localparam logic [7:0] IPR_OFF_PENDING_LO = 8'hF1;
	localparam logic [7:0] IPR_OFF_PENDING_HI = 8'hF2;

	localparam logic [7:0] IPR_PRIO_RESET = 8'h00;
	localparam logic [7:0] IPR_PRIO_MASK = 8'h3F;
	localparam logic [7:0] IPR_READ_NONE = 8'h00;

	// Source index is the polling position, first polled at index 0
	localparam logic [2:0] IPR_SRC_GROUP [IPR_NUM_SRC] = '{
		3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2,
		3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5
	};

	localparam logic [15:0] IPR_SRC_VECTOR [IPR_NUM_SRC] = '{
		16'h0003, 16'h0043, 16'h000B, 16'h008B, 16'h004B, 16'h0013, 16'h0093,
		16'h0053, 16'h001B, 16'h005B, 16'h0023, 16'h0063, 16'h002B, 16'h006B
	};

	localparam int IPR_DETECT_MCYC = 1;
	localparam int IPR_CALL_MCYC = 6;

	typedef enum logic [1:0] {
		IPR_ST_IDLE,
		IPR_ST_DETECT,
		IPR_ST_CALL
	} ipr_state_e;

endpackage

// ===== ipr_group_level.sv
/*
 * Decodes one group's priority level from its pair of select bits.
 * Assumes both select bits come straight from the priority registers.
 */
`timescale 1ns/10ps
module ipr_group_level
	import ipr_pkg::*;
(
	input wire logic sel_low,
	input wire logic sel_high,
	output logic [IPR_LVL_W-1:0] level
);

	// High select is the upper level bit, low select the lower
	assign level = {sel_high, sel_low};

endmodule

// ===== ipr_poll_pick.sv
/*
 * Picks the winning request: highest level first, then polling order.
 * Assumes request index equals polling position.
 */
`timescale 1ns/10ps
module ipr_poll_pick
	import ipr_pkg::*;
#(
	parameter int N = IPR_NUM_SRC
)
(
	input wire logic [N-1:0] eligible,
	input wire logic [N*IPR_LVL_W-1:0] src_level,
	output logic found,
	output logic [IPR_SRC_W-1:0] win_idx,
	output logic [IPR_LVL_W-1:0] win_level
);

	always_comb begin
		found = 1'b0;
		win_idx = '0;
		win_level = '0;
		// Scan levels high to low; within a level the lowest index wins
		for (int l = IPR_NUM_LVL - 1; l >= 0; l--) begin
			for (int i = 0; i < N; i++) begin
				if (!found && eligible[i] &&
					src_level[i*IPR_LVL_W +: IPR_LVL_W] == IPR_LVL_W'(l)) begin
					found = 1'b1;
					win_idx = IPR_SRC_W'(i);
					win_level = IPR_LVL_W'(l);
				end
			end
		end
	end

endmodule

// ===== ipr_resolver_props.sv
/* Port checker for ipr_resolver.
 * Assumes one clock per machine cycle. */
`timescale 1ns/10ps
module ipr_resolver_props
	import ipr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [13:0] src_request,
	input wire logic [13:0] src_enable,
	input wire logic global_irq_enable,
	input wire logic irq_take,
	input wire logic [15:0] irq_vector,
	input wire logic [3:0] irq_source,
	input wire logic [13:0] irq_ack,
	input wire logic service_busy,
	input wire logic [1:0] service_level
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [13:0] elig;
	assign elig = src_request & src_enable & {14{global_irq_enable}};
	AST_UPPER_ZERO: assert property (reg_rd && reg_addr[3:0] == 4'h9 |=>
		reg_rdata[7:6] == 2'h0) else $error("upper bits set");
	AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("stale rdata");
	AST_TAKE_GAP: assert property (irq_take |=> !irq_take [*7]) else $error("gap");
	AST_ACK: assert property (irq_ack == (irq_take ? 14'h1 << irq_source : 14'h0))
		else $error("ack");
	AST_VECTOR: assert property (irq_take |-> irq_vector == IPR_SRC_VECTOR[irq_source])
		else $error("vector");
	AST_ELIG: assert property (irq_take |-> ($past(elig, 8) >> irq_source) & 14'h1)
		else $error("not eligible");
	AST_PREEMPT: assert property (irq_take && $past(service_busy) |->
		service_level > $past(service_level)) else $error("preempt");
	AST_BUSY: assert property (irq_take |-> service_busy) else $error("busy");
	cover property (irq_take);
	cover property (irq_take && $past(service_busy));
	cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule
bind ipr_resolver ipr_resolver_props u_props (.clk_sys(clk_sys), .rst(rst),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.src_request(src_request), .src_enable(src_enable),
	.global_irq_enable(global_irq_enable), .irq_take(irq_take), .irq_vector(irq_vector),
	.irq_source(irq_source), .irq_ack(irq_ack), .service_busy(service_busy),
	.service_level(service_level));

// ===== ipr_core_model.sv
/* Core and request sources: flags set by pulses, cleared on ack.
 * Only the innermost routine runs, so returns come last in first out. */
`timescale 1ns/10ps
module ipr_core_model #(
	parameter int RET_CLKS = 60
)(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic irq_take,
	input wire logic [13:0] irq_ack,
	input wire logic [13:0] set_req,
	output logic [13:0] src_request = 14'h0,
	output logic ret_from_irq = 1'b0
);
	int left[$];
	// Return strobe is written once per edge, from the count before it steps
	always @(posedge clk_sys) begin
		if (rst) begin
			src_request <= 14'h0;
			ret_from_irq <= 1'b0;
			left.delete();
		end else begin
			src_request <= (src_request & ~irq_ack) | set_req;
			ret_from_irq <= left.size() > 0 && left[$] == 1;
			if (left.size() > 0) begin
				left[$] = left[$] - 1;
				if (left[$] == 0)
					void'(left.pop_back());
			end
			if (irq_take)
				left.push_back(RET_CLKS);
		end
	end
endmodule

// ===== test_ipr_resolver.sv
/* Bench for ipr_resolver: registers, random priority trials, nested routines tracked level by level.
 * Assumes the core model returns each routine after a fixed delay. */
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin num_errors++; \
	$display("[ERR] %s exp %0h got %0h", n, e, s); end end
module test_ipr_resolver
	import ipr_pkg::*;
;
	logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, global_irq_enable = 0;
	logic irq_take, service_busy, ret_from_irq;
	logic [15:0] irq_vector;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, lo, hi;
	logic [13:0] src_enable = 0, set_req = 0, src_request, irq_ack;
	logic [3:0] irq_source;
	logic [1:0] service_level;
	int num_errors = 0, compares = 0, pend, want, lv[$], grp[14] = '{0,0,1,1,1,2,2,2,3,3,4,4,5,5};
	ipr_resolver uut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.src_request(src_request), .src_enable(src_enable),
		.global_irq_enable(global_irq_enable), .ret_from_irq(ret_from_irq),
		.irq_take(irq_take), .irq_vector(irq_vector), .irq_source(irq_source), .irq_ack(irq_ack),
		.service_busy(service_busy), .service_level(service_level));
	ipr_core_model core (.clk_sys(clk_sys), .rst(rst), .irq_take(irq_take),
		.irq_ack(irq_ack), .set_req(set_req), .src_request(src_request),
		.ret_from_irq(ret_from_irq));
	initial forever #2 clk_sys = ~clk_sys;
	function int lvl(int i);
		return {hi[grp[i]], lo[grp[i]]};
	endfunction
	function int top();
		top = -1;
		foreach (lv[i]) if (lv[i] > top) top = lv[i];
	endfunction
	// Strict compare keeps the earliest polled source on a tie
	function int pick();
		pick = -1;
		for (int i = 0; i < 14; i++)
			if (pend[i] && src_enable[i] && global_irq_enable && lvl(i) > top() &&
				(pick < 0 || lvl(i) > lvl(pick))) pick = i;
	endfunction
	always @(posedge clk_sys) begin
		if (rst) lv.delete();
		else begin
			if (ret_from_irq) begin
				lv.sort();
				void'(lv.pop_back());
			end
			if (irq_take) begin
				want = pick();
				`CHK("source", want, irq_source)
				`CHK("vector", want < 0 ? 16'h0 : IPR_SRC_VECTOR[want], irq_vector)
				`CHK("ack", 14'(1 << want), irq_ack)
				lv.push_back(lvl(irq_source));
				pend[irq_source] = 0;
				`CHK("level", top(), service_level)
			end
		end
	end
	task wr(logic [7:0] a, logic [7:0] d);
		reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
		@(posedge clk_sys); reg_wr <= 0;
		@(posedge clk_sys);
	endtask
	task rd(logic [7:0] a, int e);
		reg_addr <= a; reg_rd <= 1;
		@(posedge clk_sys);
		reg_rd <= 0;
		// Data stands for one cycle only; look mid-cycle, away from the edges
		@(negedge clk_sys);
		`CHK("rdata", e, reg_rdata)
		@(posedge clk_sys);
	endtask
	task tally_and_finish;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#300000 num_errors++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(38007));
		for (int t = 0; t < 24; t++) begin
			rst <= 1;
			repeat (3) @(posedge clk_sys);
			rst <= 0;
			rd(IPR_OFF_PRIO_LOW, 0);
			rd(IPR_OFF_PRIO_HIGH, 0);
			// Two trials put every group on one level to expose the polling order
			lo = t < 2 ? 8'h3F * t : $urandom;
			hi = t < 2 ? 8'h3F * t : $urandom;
			wr(IPR_OFF_PRIO_LOW, lo);
			wr(IPR_OFF_PRIO_HIGH, hi);
			rd(IPR_OFF_PRIO_LOW, lo & 8'h3F);
			rd(IPR_OFF_PRIO_HIGH, hi & 8'h3F);
			rd(8'hA8, 0);
			pend = t < 2 ? 14'h3FFF : $urandom & 14'h3FFF;
			src_enable <= t < 6 ? 14'h3FFF : 14'($urandom);
			global_irq_enable <= t != 3;
			set_req <= 14'(pend);
			@(posedge clk_sys);
			set_req <= 0;
			// Both reads land before the first take, so nothing is in service yet
			rd(IPR_OFF_PENDING_LO, pend & src_enable & {14{global_irq_enable}} & 8'hFF);
			rd(IPR_OFF_PENDING_HI, (pend & src_enable & {14{global_irq_enable}}) >> 8);
			repeat (10) @(posedge clk_sys);
			for (int w = 0; w < 3000 && (lv.size() > 0 || pick() >= 0); w++)
				@(posedge clk_sys);
			@(negedge clk_sys);
			`CHK("pending", -1, pick())
			`CHK("busy", 1'b0, service_busy)
			`CHK("depth", 0, lv.size())
			@(posedge clk_sys);
			rd(IPR_OFF_SERVICE_STAT, 0);
		end
		tally_and_finish();
	end
endmodule
